// [inc/move_exec_pkg.sv]
// Behaviour
// - File move: d=0 to acc, d=1 back
// - a=0 access bank, a=1 bank register
// - a=0, extension on, f<=5Fh: indexed
// - File move decoded 0101_00da, sets N,Z
// - Mem move words 1100+src, 1111+dst, 12-bit
// - Mem move allows acc, keeps flags
// - Mem move: two cycles, dest at Q4
// - Bank load keeps bank bits 7:4 zero
// - Literal load to acc, flags unchanged
// - Acc to file move, flags unchanged
// - File move: decode,read,process,write quarters
package move_exec_pkg;
  // Register byte offsets on the bus
  localparam logic [4:0] ADR_CTRL = 5'h00;
  localparam logic [4:0] ADR_INSTR = 5'h04;
  localparam logic [4:0] ADR_ACC = 5'h08;
  localparam logic [4:0] ADR_STAT = 5'h0C;
  localparam logic [4:0] ADR_BANK = 5'h10;
  localparam logic [4:0] ADR_MADDR = 5'h14;
  localparam logic [4:0] ADR_MDATA = 5'h18;
  localparam logic [4:0] ADR_INDEX = 5'h1C;
  // Field positions
  localparam int CTRL_EXT = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ZERO = 1;
  localparam int STAT_NEG = 2;
  localparam int STAT_WAIT2 = 3;
  localparam int INS_DEST = 9;
  localparam int INS_ACCESS = 8;
  // Reset values
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [3:0] RST_BANK = 4'h0;
  localparam logic [11:0] RST_ADDR = 12'h000;
  localparam logic [15:0] RST_INSTR = 16'h0000;
  // Opcodes
  localparam logic [5:0] OP_FILE_TO_DEST = 6'h14;
  localparam logic [3:0] OP_MEM_SRC = 4'hC;
  localparam logic [3:0] OP_MEM_DST = 4'hF;
  localparam logic [7:0] OP_BANK_LIT = 8'h01;
  localparam logic [7:0] OP_ACC_LIT = 8'h0E;
  localparam logic [6:0] OP_ACC_TO_FILE = 7'h37;
  // Addressing
  localparam logic [7:0] INDEX_LIMIT = 8'h5F;
  localparam logic [3:0] ACCESS_HIGH_PAGE = 4'hF;
  localparam logic [3:0] ACCESS_LOW_PAGE = 4'h0;
  localparam logic [11:0] ACC_DATA_ADDR = 12'hFF0;
  // Quarter phases, one-hot bit index
  localparam int Q1 = 0;
  localparam int Q2 = 1;
  localparam int Q3 = 2;
  localparam int Q4 = 3;
  localparam logic [3:0] QUARTER_RST = 4'h1;
  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_EXEC = 4'h2,
    ST_WAIT2 = 4'h4,
    ST_EXEC2 = 4'h8
  } exec_state_type;
endpackage

// [inc/quarter_if.sv]
`timescale 1ns/100ps
// Quarter phase of the instruction cycle, one-hot
interface quarter_if;
  logic [3:0] quarter;
  modport drive (output quarter);
  modport watch (input quarter);
endinterface

// [hw/quarter_gen.sv]
`timescale 1ns/100ps
module quarter_gen (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Phase out
  quarter_if.drive qif
);
  import move_exec_pkg::*;

  typedef struct packed {
    logic [3:0] q; // One-hot quarter
  } phase_type;

  phase_type cur;
  phase_type next_cur;

  ////////////////////////////////////////////////////////////////
  // Rotate one quarter per clock, four clocks per cycle
  always_comb begin
    next_cur = cur;
    next_cur.q = {cur.q[2:0], cur.q[3]};
  end

  // State register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur.q <= QUARTER_RST;
    end else begin
      cur <= next_cur;
    end
  end

  assign qif.quarter = cur.q;

  ////////////////////////////////////////////////////////////////
  phase_rotate_a: assert property (@(posedge clk) disable iff (sys_rst)
    cur.q[Q1] |-> ##1 cur.q[Q2] ##1 cur.q[Q3] ##1 cur.q[Q4] ##1 cur.q[Q1])
    else $error("quarter phase out of order");
endmodule // quarter_gen

// [hw/data_addr_former.sv]
`timescale 1ns/100ps
module data_addr_former (
  // Operand
  input wire logic [7:0] file_addr,
  input wire logic access_sel,
  // Context
  input wire logic [3:0] bank,
  input wire logic ext_en,
  input wire logic [11:0] index_base,
  // Result
  output logic [11:0] data_addr
);
  import move_exec_pkg::*;

  ////////////////////////////////////////////////////////////////
  // Pick banked, indexed or access bank address
  always_comb begin
    if (access_sel) begin
      data_addr = {bank, file_addr};
    end else if (ext_en && (file_addr <= INDEX_LIMIT)) begin
      data_addr = 12'(index_base + {4'h0, file_addr});
    end else if (file_addr[7]) begin
      // Upper half of the access bank maps onto the top page
      data_addr = {ACCESS_HIGH_PAGE, file_addr};
    end else begin
      data_addr = {ACCESS_LOW_PAGE, file_addr};
    end
  end
endmodule // data_addr_former

// [hw/data_move_exec.sv]
// The register offsets and register access over Wishbone were decided locally.
`timescale 1ns/100ps
module data_move_exec (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import move_exec_pkg::*;

  ////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    exec_state_type st; // Sequencer
    logic pend; // Instruction word waiting for Q1
    logic ext_en; // Extended instruction set on
    logic [15:0] instr; // Current instruction word
    logic [7:0] w; // Working register
    logic [3:0] bank_select_reg; // Bank select, upper bits fixed zero
    logic neg; // Negative flag
    logic zero; // Zero flag
    logic [11:0] index_base; // Base for indexed literal offset
    logic [11:0] maddr; // Software data pointer
    logic [11:0] ea; // Effective address of the operand
    logic [7:0] hold; // Value read in Q2
    logic ack; // Bus answer
    logic [31:0] dat; // Bus read data
  } core_type;

  core_type cur;
  core_type next_cur;

  logic [7:0] data_mem [0:4095]; // Data space, 4096 bytes
  logic mem_we; // Data space write strobe
  logic [11:0] mem_wa; // Data space write address
  logic [7:0] mem_wd; // Data space write data
  logic [11:0] file_ea; // Address from the file operand
  logic [31:0] bus_rd; // Read value at the bus address
  logic [31:0] lane_mask; // Byte lane mask from sel
  logic [31:0] bus_wv; // Merged write value
  logic bus_req; // Live request
  logic idle_like; // Sequencer can take a word

  quarter_if qif ();

  ////////////////////////////////////////////////////////////////
  // Phase and address helpers
  quarter_gen u_phase (
    .clk(clk),
    .sys_rst(sys_rst),
    .qif(qif)
  );

  data_addr_former u_addr (
    .file_addr(cur.instr[7:0]),
    .access_sel(cur.instr[INS_ACCESS]),
    .bank(cur.bank_select_reg),
    .ext_en(cur.ext_en),
    .index_base(cur.index_base),
    .data_addr(file_ea)
  );

  // Instruction classes from the held word
  // Words that match none of these run as no-ops
  logic is_move_file_to_dest;
  logic is_src;
  logic is_dst;
  logic is_bank;
  logic is_lit;
  logic is_move_acc_to_file;
  assign is_move_file_to_dest = cur.instr[15:10] == OP_FILE_TO_DEST;
  assign is_src = cur.instr[15:12] == OP_MEM_SRC;
  assign is_dst = cur.instr[15:12] == OP_MEM_DST;
  assign is_bank = cur.instr[15:8] == OP_BANK_LIT;
  assign is_lit = cur.instr[15:8] == OP_ACC_LIT;
  assign is_move_acc_to_file = cur.instr[15:9] == OP_ACC_TO_FILE;

  // Data space read, the working register shadows its own address
  // Other bytes come from the array and read unknown until first written
  function automatic logic [7:0] rd_data(input logic [11:0] a, input logic [7:0] w);
    rd_data = (a == ACC_DATA_ADDR) ? w : data_mem[a];
  endfunction

  ////////////////////////////////////////////////////////////////
  // Bus read multiplexer, unmapped offsets read zero
  always_comb begin
    bus_rd = 32'h0000_0000;
    unique case (wb_adr_i)
      ADR_CTRL: bus_rd[CTRL_EXT] = cur.ext_en;
      ADR_INSTR: bus_rd[15:0] = cur.instr;
      ADR_ACC: bus_rd[7:0] = cur.w;
      ADR_STAT: begin
        // Busy stays up while a memory move waits for its second word
        bus_rd[STAT_BUSY] = (cur.st != ST_IDLE) || cur.pend;
        bus_rd[STAT_ZERO] = cur.zero;
        bus_rd[STAT_NEG] = cur.neg;
        bus_rd[STAT_WAIT2] = cur.st == ST_WAIT2;
      end
      ADR_BANK: bus_rd[3:0] = cur.bank_select_reg;
      ADR_MADDR: bus_rd[11:0] = cur.maddr;
      ADR_MDATA: bus_rd[7:0] = rd_data(cur.maddr, cur.w);
      ADR_INDEX: bus_rd[11:0] = cur.index_base;
      default: bus_rd = 32'h0000_0000;
    endcase
  end

  // Byte lanes not selected keep their old value
  assign lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign bus_wv = (bus_rd & ~lane_mask) | (wb_dat_i & lane_mask);
  assign bus_req = wb_cyc_i && wb_stb_i;
  assign idle_like = (cur.st == ST_IDLE || cur.st == ST_WAIT2) && !cur.pend;

  ////////////////////////////////////////////////////////////////
  // Next state: bus slave first, engine after so it wins clashes
  always_comb begin
    next_cur = cur;
    mem_we = 1'b0;
    mem_wa = cur.maddr;
    mem_wd = bus_wv[7:0];
    // Answer one cycle after the request, drop it the cycle after
    next_cur.ack = bus_req && !cur.ack;
    if (bus_req && !cur.ack && !wb_we_i) begin
      next_cur.dat = bus_rd;
    end
    // Writes land on the edge where the master sees ack
    if (bus_req && cur.ack && wb_we_i) begin
      unique case (wb_adr_i)
        ADR_CTRL: next_cur.ext_en = bus_wv[CTRL_EXT];
        ADR_INSTR: begin
          // A word sent while busy is dropped unless the sequencer waits in ST_WAIT2; poll busy first
          if (idle_like) begin
            next_cur.instr = bus_wv[15:0];
            next_cur.pend = 1'b1;
          end
        end
        ADR_ACC: next_cur.w = bus_wv[7:0];
        ADR_BANK: next_cur.bank_select_reg = bus_wv[3:0];
        ADR_MADDR: next_cur.maddr = bus_wv[11:0];
        ADR_MDATA: begin
          // Memory stores share the single write port with the engine
          if (cur.maddr == ACC_DATA_ADDR) begin
            next_cur.w = bus_wv[7:0];
          end else begin
            mem_we = 1'b1;
          end
        end
        ADR_INDEX: next_cur.index_base = bus_wv[11:0];
        default: next_cur.ext_en = cur.ext_en;
      endcase
    end
    // Instruction engine
    // Quarters: Q1 decode, Q2 read, Q3 process, Q4 write
    unique case (cur.st)
      ST_IDLE, ST_WAIT2: begin
        // Start on the cycle boundary so the word sees a full Q1..Q4
        if (cur.pend && qif.quarter[Q4]) begin
          next_cur.st = (cur.st == ST_WAIT2) ? ST_EXEC2 : ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (qif.quarter[Q1]) begin
          next_cur.pend = 1'b0;
        end
        if (qif.quarter[Q2]) begin
          // Read the operand or take the literal
          if (is_src) begin
            next_cur.ea = cur.instr[11:0];
            next_cur.hold = rd_data(cur.instr[11:0], cur.w);
          end else if (is_move_file_to_dest) begin
            next_cur.ea = file_ea;
            next_cur.hold = rd_data(file_ea, cur.w);
          end else begin
            next_cur.ea = file_ea;
            next_cur.hold = cur.instr[7:0];
          end
        end
        if (qif.quarter[Q4]) begin
          next_cur.st = is_src ? ST_WAIT2 : ST_IDLE;
          if (is_move_file_to_dest) begin
            // Flags follow the moved value
            next_cur.neg = cur.hold[7];
            next_cur.zero = cur.hold == 8'h00;
            if (cur.instr[INS_DEST] == 1'b0 || cur.ea == ACC_DATA_ADDR) begin
              next_cur.w = cur.hold;
            end else begin
              mem_we = 1'b1;
              mem_wa = cur.ea;
              mem_wd = cur.hold;
            end
          end else if (is_bank) begin
            next_cur.bank_select_reg = cur.hold[3:0];
          end else if (is_lit) begin
            next_cur.w = cur.hold;
          end else if (is_move_acc_to_file) begin
            // W's own address needs no store: W already holds the value
            if (cur.ea != ACC_DATA_ADDR) begin
              mem_we = 1'b1;
              mem_wa = cur.ea;
              mem_wd = cur.w;
            end
          end
        end
      end
      ST_EXEC2: begin
        // Second word: no dummy read, write lands in Q4
        if (qif.quarter[Q1]) begin
          next_cur.pend = 1'b0;
        end
        // Only the destination is latched; the source byte waits in hold
        if (qif.quarter[Q2] && is_dst) begin
          next_cur.ea = cur.instr[11:0];
        end
        if (qif.quarter[Q4]) begin
          next_cur.st = ST_IDLE;
          if (is_dst) begin
            if (cur.ea == ACC_DATA_ADDR) begin
              next_cur.w = cur.hold;
            end else begin
              mem_we = 1'b1;
              mem_wa = cur.ea;
              mem_wd = cur.hold;
            end
          end
        end
      end
      // Illegal state codes fall back to idle
      default: next_cur.st = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur.st <= ST_IDLE;
      cur.pend <= 1'b0;
      cur.ext_en <= 1'b0;
      cur.instr <= RST_INSTR;
      cur.w <= RST_ACC;
      cur.bank_select_reg <= RST_BANK;
      cur.neg <= 1'b0;
      cur.zero <= 1'b0;
      cur.index_base <= RST_ADDR;
      cur.maddr <= RST_ADDR;
      cur.ea <= RST_ADDR;
      cur.hold <= RST_ACC;
      cur.ack <= 1'b0;
      cur.dat <= 32'h0000_0000;
    end else begin
      cur <= next_cur;
    end
  end

  // Data space, no reset: contents are undefined at power-up
  always_ff @(posedge clk) begin
    if (mem_we) begin
      data_mem[mem_wa] <= mem_wd;
    end
  end

  // Bus outputs come straight from the state flops
  assign wb_ack_o = cur.ack;
  assign wb_dat_o = cur.dat;

  ////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic exec_q4; // Last quarter of a first-word cycle
  assign exec_q4 = cur.st == ST_EXEC && qif.quarter[Q4];
  logic bus_store; // Bus store to the data space on this edge
  assign bus_store = bus_req && cur.ack && wb_we_i && wb_adr_i == ADR_MDATA;
  // Pc and return-stack destinations are left to software; nothing guards them here

  sequence src_cycle_end;
    exec_q4 && is_src;
  endsequence

  sequence second_write;
    cur.st == ST_EXEC2 && qif.quarter[Q4] && is_dst && cur.ea != ACC_DATA_ADDR;
  endsequence

  acc_dest_a: assert property (exec_q4 && is_move_file_to_dest && !cur.instr[INS_DEST]
    |=> cur.w == $past(cur.hold)) else $error("file move did not reach acc");
  file_dest_a: assert property (exec_q4 && is_move_file_to_dest && cur.instr[INS_DEST]
    && cur.ea != ACC_DATA_ADDR |-> mem_we && mem_wa == cur.ea && mem_wd == cur.hold)
    else $error("file move did not write back");
  bank_addr_a: assert property (cur.instr[INS_ACCESS]
    |-> file_ea == {cur.bank_select_reg, cur.instr[7:0]}) else $error("banked address wrong");
  access_addr_a: assert property (!cur.instr[INS_ACCESS]
    && !(cur.ext_en && cur.instr[7:0] <= INDEX_LIMIT) |-> file_ea[7:0] == cur.instr[7:0]
    && file_ea[11:8] == (cur.instr[7] ? ACCESS_HIGH_PAGE : ACCESS_LOW_PAGE))
    else $error("access bank address wrong");
  indexed_addr_a: assert property (!cur.instr[INS_ACCESS] && cur.ext_en
    && cur.instr[7:0] <= INDEX_LIMIT |-> file_ea == cur.index_base + {4'h0, cur.instr[7:0]})
    else $error("indexed address wrong");
  move_flags_a: assert property (exec_q4 && is_move_file_to_dest
    |=> cur.zero == ($past(cur.hold) == 8'h00) && cur.neg == $past(cur.hold[7]))
    else $error("file move flags wrong");
  flags_kept_a: assert property ($changed({cur.neg, cur.zero})
    |-> $past(exec_q4 && is_move_file_to_dest)) else $error("flags changed by flag-free move");
  mem_wait_a: assert property (src_cycle_end |=> cur.st == ST_WAIT2)
    else $error("memory move did not wait for second word");
  mem_write_a: assert property (second_write
    |-> mem_we && mem_wa == cur.ea && mem_wd == cur.hold ##1 cur.st == ST_IDLE)
    else $error("memory move destination not written");
  // A bus store may land in any quarter; only engine stores are held to Q4
  quarter_write_a: assert property (mem_we && (cur.st == ST_EXEC || cur.st == ST_EXEC2)
    && !bus_store |-> qif.quarter[Q4]) else $error("engine wrote outside Q4");
  bank_load_a: assert property (exec_q4 && is_bank
    |=> cur.bank_select_reg == $past(cur.instr[3:0]) && (bus_rd[31:4] == 28'h000_0000 || wb_adr_i != ADR_BANK))
    else $error("bank load wrong");
  lit_load_a: assert property (exec_q4 && is_lit |=> cur.w == $past(cur.instr[7:0]))
    else $error("literal load wrong");
  acc_store_a: assert property (exec_q4 && is_move_acc_to_file && cur.ea != ACC_DATA_ADDR
    |-> mem_we && mem_wa == cur.ea && mem_wd == cur.w) else $error("acc store wrong");

  // Bus handshake: a new request is answered next cycle, for one cycle only
  sequence bus_taken;
    bus_req && !cur.ack;
  endsequence

  sequence instr_store_busy;
    bus_req && cur.ack && wb_we_i && wb_adr_i == ADR_INSTR && !idle_like;
  endsequence

  ack_answer_a: assert property (bus_taken |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer is not a one-cycle pulse");
  // Read data is taken on the request edge and stands with ack
  read_capture_a: assert property (bus_req && !cur.ack && !wb_we_i
    |=> wb_dat_o == $past(bus_rd)) else $error("read data not taken at the request edge");
  // A word sent while busy must leave the word in flight alone
  instr_drop_a: assert property (instr_store_busy |=> cur.instr == $past(cur.instr))
    else $error("busy instruction word accepted");
endmodule // data_move_exec

// [verification/tb_data_move_exec.sv]
`timescale 1ns/100ps
module tb_data_move_exec;
  import move_exec_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // Clock, reset and bus signals of the block
  logic clk;
  logic sys_rst;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_we_i;
  logic [4:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  // Expected read note: mask zero means a poll that is not compared
  typedef struct {logic [4:0] adr; logic [31:0] val; logic [31:0] mask;} exp_type;
  exp_type exp_q[$];
  int err_total = 0;
  int n_compared = 0;
  int cyc_cnt = 0;
  logic [15:0] rnd = 16'h8061;
  logic [3:0] sel_v = 4'hF;
  // Reference state of the block
  logic [7:0] mem [0:4095];
  logic [7:0] acc_m = 8'h00;
  logic [3:0] bank_m = 4'h0;
  logic ext_m = 1'b0;
  logic [11:0] idx_m = 12'h000;
  logic [1:0] nz_m = 2'b00;
  // Offsets read back as zero straight after reset
  logic [4:0] u_ofs [7] = '{ADR_CTRL, ADR_INSTR, ADR_ACC, ADR_STAT, ADR_BANK, ADR_MADDR,
    ADR_INDEX};

  data_move_exec u_data_move_exec (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 10 MHz
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Next pseudo-random word
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Data address the engine should reach for operand f
  function automatic logic [11:0] ea(input logic [7:0] f, input logic a);
    if (a) return {bank_m, f};
    if (ext_m && f <= INDEX_LIMIT) return idx_m + {4'h0, f};
    return f[7] ? {ACCESS_HIGH_PAGE, f} : {ACCESS_LOW_PAGE, f};
  endfunction

  // Data space read, with the accumulator alias
  function automatic logic [7:0] mrd(input logic [11:0] ad);
    return (ad == ACC_DATA_ADDR) ? acc_m : mem[ad];
  endfunction

  task automatic mwr(input logic [11:0] ad, input logic [7:0] v);
    if (ad == ACC_DATA_ADDR) acc_m = v;
    else mem[ad] = v;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Comparison and closing
  task automatic check(input logic [4:0] adr, input logic [31:0] seen, input logic [31:0] ex);
    n_compared++;
    if (seen !== ex) begin
      err_total++;
      $display("CHECK FAILED reg %h expected %h seen %h", adr, ex, seen);
    end
  endtask

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Hang guard, far above the thousand or so cycles the run needs
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_total++;
      finish_test();
    end
  end

  // Watcher: read data is taken at the ack edge only
  always @(posedge clk) begin
    exp_type e;
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e.mask != 0) check(e.adr, wb_dat_o & e.mask, e.val & e.mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Classic single cycle; request held until ack is sampled high
  task automatic bus(input logic we, input logic [4:0] adr, input logic [31:0] dat,
    output logic [31:0] q);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel_v;
    @(posedge clk);
    while (wb_ack_o !== 1'b1) @(posedge clk);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    // Idle cycle between requests
    @(posedge clk);
  endtask

  task automatic wr(input logic [4:0] adr, input logic [31:0] dat);
    logic [31:0] q;
    bus(1'b1, adr, dat, q);
  endtask

  task automatic rd(input logic [4:0] adr, input logic [31:0] ex, input logic [31:0] m);
    logic [31:0] q;
    exp_q.push_back('{adr, ex, m});
    bus(1'b0, adr, 32'h0000_0000, q);
  endtask

  // Issue one word, then poll status until busy and waiting both match pend;
  // busy stays up while a memory move waits for its second word
  task automatic run(input logic [15:0] ins, input logic pend);
    logic [31:0] q;
    wr(ADR_INSTR, {16'h0000, ins});
    repeat (8) @(posedge clk);
    do begin
      exp_q.push_back('{ADR_STAT, 32'h0000_0000, 32'h0000_0000});
      bus(1'b0, ADR_STAT, 32'h0000_0000, q);
    end while (q[STAT_BUSY] !== pend || q[STAT_WAIT2] !== pend);
  endtask

  task automatic put(input logic [11:0] ad, input logic [7:0] v);
    wr(ADR_MADDR, {20'h0_0000, ad});
    wr(ADR_MDATA, {24'h00_0000, v});
    mwr(ad, v);
  endtask

  task automatic chk_mem(input logic [11:0] ad);
    wr(ADR_MADDR, {20'h0_0000, ad});
    rd(ADR_MDATA, {24'h00_0000, mrd(ad)}, 32'h0000_00FF);
  endtask

  // Status flags as the model holds them
  task automatic chk_flags();
    rd(ADR_STAT, {29'h0, nz_m, 1'b0}, 32'h0000_0006);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [7:0] f;
    logic [7:0] v;
    logic [11:0] ad;
    logic [11:0] src_t [3];
    logic [11:0] dst_t [3];
    sys_rst = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 5'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0000_0000;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    // Reset values, then an unmapped offset that reads zero
    foreach (u_ofs[i]) rd(u_ofs[i], 32'h0000_0000, 32'hFFFF_FFFF);
    wr(5'h09, 32'h0000_00FF);
    rd(5'h09, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(ADR_ACC, 32'h0000_0000, 32'h0000_00FF);
    // No byte lane selected: the write must leave the register alone
    sel_v = 4'h0;
    wr(ADR_ACC, 32'h0000_005A);
    sel_v = 4'hF;
    rd(ADR_ACC, 32'h0000_0000, 32'h0000_00FF);
    // Bank register upper bits stay zero, by bus and by instruction
    wr(ADR_BANK, 32'h0000_00FF);
    rd(ADR_BANK, 32'h0000_000F, 32'h0000_00FF);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      run({OP_BANK_LIT, rnd[7:4] | 4'h8, rnd[3:0]}, 1'b0);
      bank_m = rnd[3:0];
      rd(ADR_BANK, {28'h0, bank_m}, 32'h0000_00FF);
    end
    // File move: every d and a, with zero, negative and random values
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      f = rnd[15:8];
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'h80 : rnd[7:0];
      ad = ea(f, i[1]);
      put(ad, v);
      run({OP_FILE_TO_DEST, i[0], i[1], f}, 1'b0);
      if (!i[0]) acc_m = v;
      nz_m = {v[7], v == 8'h00};
      rd(ADR_ACC, {24'h0, acc_m}, 32'h0000_00FF);
      chk_mem(ad);
      chk_flags();
    end
    // Indexed operand at the limit, plain access one above it
    wr(ADR_CTRL, 32'h0000_0001);
    ext_m = 1'b1;
    rnd = lfsr(rnd);
    idx_m = {1'b0, rnd[10:0]};
    wr(ADR_INDEX, {20'h0_0000, idx_m});
    for (int i = 0; i < 2; i++) begin
      f = INDEX_LIMIT + i[7:0];
      rnd = lfsr(rnd);
      put(ea(f, 1'b0), rnd[7:0] | 8'h01);
      run({OP_FILE_TO_DEST, 2'b00, f}, 1'b0);
      acc_m = rnd[7:0] | 8'h01;
      nz_m = {acc_m[7], 1'b0};
      rd(ADR_ACC, {24'h0, acc_m}, 32'h0000_00FF);
    end
    wr(ADR_CTRL, 32'h0000_0000);
    ext_m = 1'b0;
    // Literal load, flags untouched
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'h80 : rnd[7:0];
      run({OP_ACC_LIT, v}, 1'b0);
      acc_m = v;
      rd(ADR_ACC, {24'h0, acc_m}, 32'h0000_00FF);
      chk_flags();
    end
    // Accumulator to file in both addressing modes
    for (int i = 0; i < 2; i++) begin
      rnd = lfsr(rnd);
      f = rnd[15:8];
      wr(ADR_ACC, {24'h0, rnd[7:0]});
      acc_m = rnd[7:0];
      ad = ea(f, i[0]);
      if (ad != ACC_DATA_ADDR) put(ad, ~acc_m);
      run({OP_ACC_TO_FILE, i[0], f}, 1'b0);
      mwr(ad, acc_m);
      chk_mem(ad);
      chk_flags();
    end
    // Memory move: plain, from the accumulator, into it; dst avoids pc and stack bytes
    rnd = lfsr(rnd);
    src_t = '{{1'b0, rnd[10:0]}, ACC_DATA_ADDR, 12'hFFE};
    dst_t = '{12'h000, {1'b0, rnd[15:5]}, ACC_DATA_ADDR};
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      if (src_t[i] != ACC_DATA_ADDR) put(src_t[i], rnd[7:0]);
      if (dst_t[i] != ACC_DATA_ADDR) put(dst_t[i], ~mrd(src_t[i]));
      run({OP_MEM_SRC, src_t[i]}, 1'b1);
      run({OP_MEM_DST, dst_t[i]}, 1'b0);
      mwr(dst_t[i], mrd(src_t[i]));
      chk_mem(dst_t[i]);
      rd(ADR_ACC, {24'h0, acc_m}, 32'h0000_00FF);
      chk_flags();
    end
    // A word written while busy is dropped, the first one wins
    wr(ADR_INSTR, {16'h0000, OP_ACC_LIT, 8'h3C});
    wr(ADR_INSTR, {16'h0000, OP_ACC_LIT, 8'hC3});
    run({OP_MEM_DST, 12'h000}, 1'b0);
    acc_m = 8'h3C;
    rd(ADR_ACC, {24'h0, acc_m}, 32'h0000_00FF);
    repeat (4) @(posedge clk);
    finish_test();
  end

endmodule // tb_data_move_exec
